// file: hdl/tsc_regs.sv
// Register bank, conversion sequencing, offset correction and limit checking of the thermometer.
//
// Overview of operation
// R1: Remote offset is 10 bits: high byte at 0x11, two bits atop 0x12.
// R2: Offset high-byte MSB is sign; range -128 to +127.75 in quarter steps.
// R3: Signed offset is added to each remote result before it is stored.
// R4: Offset resets to zero so remote results pass unchanged.
// R5: Any write to 0x0F runs one conversion on both channels, then idles.
// R6: Data byte of the trigger write is discarded; nothing is stored there.
// R7: Count field bits 3..1 select one to four consecutive faults; bit 0 ignored.
// R8: At most four faults required; default alerts on the first one.
// R9: Fault count register sits at 0x22, read/write, reset value 0x01.
// R10: Local upper limit reads at 0x05, writes at 0x0B, resets to 0x55.
// R11: Remote value low byte is read-only at 0x10, high byte at 0x01.
// R12: Remote upper limit high byte reads 0x07, writes 0x0D; low byte 0x13.
// R13: Remote lower limit high byte reads 0x08, writes 0x0E; low byte 0x14.
// R14: Device is bus slave only; the host starts every access.
// R15: With timeout enabled, an idle transaction is dropped after about 25 ms.
// R16: Timeout is off after reset; setting bits 7 and 6 of 0x22 enables it.
// R17: First byte of each write transaction loads the address pointer.
// R18: Setup bit 6 set means standby: no periodic conversions, bus still works.
// R19: Writes to addresses without a writable register change nothing.
// R20: An in-limit result clears that channel's consecutive-fault count.
`timescale 1ns/100ps
module tsc_regs #(
  parameter int MS_CYCLES = tsc_pkg::MS_CYCLES,
  parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value.
  parameter logic [7:0] MAKER_ID = 8'h3c, // Arbitrary value.
  parameter logic [7:0] REV_ID = 8'h01 // Arbitrary value.
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic XFER_START,
  input wire logic XFER_STOP,
  input wire logic BUS_ACTIVE,
  input wire logic WR_VALID,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_REQ,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic BUS_TIMEOUT,
  output logic CONV_START,
  input wire logic MEAS_VALID,
  input wire logic [7:0] MEAS_LOCAL,
  input wire logic [9:0] MEAS_REMOTE,
  input wire logic MEAS_OPEN,
  output logic ALERT_N_O,
  output logic ALERT_N_OE,
  output logic CRITICAL_OVERTEMP_N_O,
  output logic CRITICAL_OVERTEMP_N_OE
);
  logic [7:0] ptr_q;
  tsc_pkg::tsc_pos_t pos_q;
  logic in_xfer_q;
  logic tmo;
  logic bus_tmo_q;
  logic wr_en;
  logic [7:0] setup_q;
  logic [7:0] rate_q;
  logic [7:0] fc_q;
  logic [7:0] loc_up_q;
  logic [7:0] loc_lo_q;
  logic [7:0] rem_up_hi_q;
  logic [7:0] rem_lo_hi_q;
  logic [1:0] rem_up_lo_q;
  logic [1:0] rem_lo_lo_q;
  logic [7:0] rem_crit_q;
  logic [7:0] loc_crit_q;
  logic [7:0] hyst_q;
  logic [7:0] ofs_hi_q;
  logic [1:0] ofs_lo_q;
  logic [7:0] loc_val_q;
  logic [9:0] rem_val_q;
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  logic [13:0] conv_ms_q;
  logic due_q;
  logic pend_q;
  logic os_act_q;
  tsc_pkg::tsc_conv_t conv_q;
  logic start_os;
  logic start_per;
  logic conv_start_q;
  logic meas_take;
  logic standby;
  logic [9:0] ofs;
  logic signed [10:0] rem_sum;
  logic [9:0] rem_new;
  logic [9:0] loc10;
  logic c_lhi;
  logic c_llo;
  logic c_rhi;
  logic c_rlo;
  logic [6:2] cond_q;
  logic [6:2] flag_q;
  logic [6:2] flag_set;
  logic rd_flags;
  logic lcrit_q;
  logic rcrit_q;
  logic alert_q;
  logic [7:0] rd_mux;
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  tsc_flt_if flt_loc ();
  tsc_flt_if flt_rem ();

  function automatic logic gt10(input logic [9:0] a, input logic [9:0] b);
    gt10 = $signed(a) > $signed(b);
  endfunction

  // Critical flag with hysteresis: sets above the limit, clears at limit minus hysteresis.
  function automatic logic crit_next(input logic cur, input logic [7:0] v,
                                     input logic [7:0] lim, input logic [7:0] hy);
    logic signed [9:0] sv;
    logic signed [9:0] sl;
    logic signed [9:0] sh;
    sv = {{2{v[7]}}, v};
    sl = {{2{lim[7]}}, lim};
    sh = {2'h0, hy};
    if (sv > sl) begin
      crit_next = 1'b1;
    end else if (sv <= sl - sh) begin
      crit_next = 1'b0;
    end else begin
      crit_next = cur;
    end
  endfunction

  // R14: host starts, device answers
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      in_xfer_q <= 1'b0;
      pos_q <= tsc_pkg::BP_IDLE;
    end else if (XFER_START) begin
      in_xfer_q <= 1'b1;
      pos_q <= tsc_pkg::BP_PTR;
    end else if (XFER_STOP || tmo) begin
      in_xfer_q <= 1'b0;
      pos_q <= tsc_pkg::BP_IDLE;
    end else if (WR_VALID && in_xfer_q) begin
      // Bytes beyond the second are dropped; the pointer write plus one data byte is the limit.
      pos_q <= (pos_q == tsc_pkg::BP_PTR) ? tsc_pkg::BP_DATA : tsc_pkg::BP_IDLE;
    end
  end

  // R17: first byte loads pointer
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ptr_q <= tsc_pkg::RST_PTR;
    end else if (WR_VALID && in_xfer_q && !XFER_START && pos_q == tsc_pkg::BP_PTR) begin
      ptr_q <= WR_DATA;
    end
  end

  assign wr_en = WR_VALID & in_xfer_q & ~XFER_START & (pos_q == tsc_pkg::BP_DATA);

  tsc_bus_timeout u_tmo (
    .clk(CLK_SYS),
    .rst_n(NRST),
    // R16: both enable bits needed
    .enable(fc_q[tsc_pkg::FC_TMO_HI] & fc_q[tsc_pkg::FC_TMO_LO]),
    .ms_tick(ms_tick),
    .in_xfer(in_xfer_q),
    .activity(BUS_ACTIVE | XFER_START),
    .timeout(tmo)
  );

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      bus_tmo_q <= 1'b0;
    end else begin
      bus_tmo_q <= tmo;
    end
  end

  // R19: unlisted addresses fall through
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      setup_q <= tsc_pkg::RST_SETUP;
      rate_q <= tsc_pkg::RST_RATE;
      fc_q <= tsc_pkg::RST_FAULT_CNT;
    end else if (wr_en) begin
      case (ptr_q)
        tsc_pkg::WA_SETUP: setup_q <= WR_DATA;
        tsc_pkg::WA_RATE: rate_q <= WR_DATA;
        // R9: fault count read/write
        tsc_pkg::A_FAULT_CNT: fc_q <= WR_DATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      loc_up_q <= tsc_pkg::RST_UP;
      loc_lo_q <= tsc_pkg::RST_ZERO;
      rem_up_hi_q <= tsc_pkg::RST_UP;
      rem_lo_hi_q <= tsc_pkg::RST_ZERO;
      rem_up_lo_q <= 2'h0;
      rem_lo_lo_q <= 2'h0;
      rem_crit_q <= tsc_pkg::RST_CRIT;
      loc_crit_q <= tsc_pkg::RST_CRIT;
      hyst_q <= tsc_pkg::RST_HYST;
    end else if (wr_en) begin
      case (ptr_q)
        // R10: local upper write address
        tsc_pkg::WA_LOC_UP: loc_up_q <= WR_DATA;
        tsc_pkg::WA_LOC_LO: loc_lo_q <= WR_DATA;
        // R12: remote upper split bytes
        tsc_pkg::WA_REM_UP_HI: rem_up_hi_q <= WR_DATA;
        tsc_pkg::A_REM_UP_LO: rem_up_lo_q <= WR_DATA[tsc_pkg::FRAC_HI:tsc_pkg::FRAC_LO];
        // R13: remote lower split bytes
        tsc_pkg::WA_REM_LO_HI: rem_lo_hi_q <= WR_DATA;
        tsc_pkg::A_REM_LO_LO: rem_lo_lo_q <= WR_DATA[tsc_pkg::FRAC_HI:tsc_pkg::FRAC_LO];
        tsc_pkg::A_REM_CRIT: rem_crit_q <= WR_DATA;
        tsc_pkg::A_LOC_CRIT: loc_crit_q <= WR_DATA;
        tsc_pkg::A_CRIT_HYST: hyst_q <= WR_DATA;
        default: ;
      endcase
    end
  end

  // R1: ten-bit offset storage
  // R4: offset resets to zero
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ofs_hi_q <= tsc_pkg::RST_ZERO;
      ofs_lo_q <= 2'h0;
    end else if (wr_en && ptr_q == tsc_pkg::A_OFS_HI) begin
      ofs_hi_q <= WR_DATA;
    end else if (wr_en && ptr_q == tsc_pkg::A_OFS_LO) begin
      ofs_lo_q <= WR_DATA[tsc_pkg::FRAC_HI:tsc_pkg::FRAC_LO];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ms_cnt_q <= 32'h0;
    end else if (ms_cnt_q >= 32'(MS_CYCLES - 1)) begin
      ms_cnt_q <= 32'h0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
    end
  end

  assign ms_tick = (ms_cnt_q >= 32'(MS_CYCLES - 1));
  assign standby = setup_q[tsc_pkg::SETUP_STBY_BIT];

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      conv_ms_q <= 14'h0;
    end else if (ms_tick) begin
      if (conv_ms_q >= tsc_pkg::rate_ms(rate_q) - 14'h1) begin
        conv_ms_q <= 14'h0;
      end else begin
        conv_ms_q <= conv_ms_q + 14'h1;
      end
    end
  end

  // R18: standby blocks periodic starts
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      due_q <= 1'b0;
    end else if (standby) begin
      due_q <= 1'b0;
    end else if (ms_tick && conv_ms_q >= tsc_pkg::rate_ms(rate_q) - 14'h1) begin
      due_q <= 1'b1;
    end else if (start_per) begin
      due_q <= 1'b0;
    end
  end

  // R6: trigger data discarded
  // R5: trigger write requests conversion
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      pend_q <= 1'b0;
    end else if (wr_en && ptr_q == tsc_pkg::WA_TRIGGER) begin
      pend_q <= 1'b1;
    end else if (start_os) begin
      pend_q <= 1'b0;
    end
  end

  assign start_os = (conv_q == tsc_pkg::CV_IDLE) & pend_q;
  assign start_per = (conv_q == tsc_pkg::CV_IDLE) & ~pend_q & due_q & ~standby;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      conv_q <= tsc_pkg::CV_IDLE;
      os_act_q <= 1'b0;
    end else begin
      case (conv_q)
        tsc_pkg::CV_IDLE: begin
          if (start_os || start_per) begin
            conv_q <= tsc_pkg::CV_WAIT;
            os_act_q <= start_os;
          end
        end
        tsc_pkg::CV_WAIT: begin
          // R18: standby aborts periodic run
          if (MEAS_VALID || (standby && !os_act_q)) begin
            conv_q <= tsc_pkg::CV_IDLE;
            os_act_q <= 1'b0;
          end
        end
        default: conv_q <= tsc_pkg::CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= start_os | start_per;
    end
  end

  // An aborted conversion is not in CV_WAIT any more, so its late result is never stored.
  assign meas_take = MEAS_VALID & (conv_q == tsc_pkg::CV_WAIT);

  // R2: sign from offset MSB
  assign ofs = {ofs_hi_q, ofs_lo_q};
  // R3: offset added before storing
  assign rem_sum = $signed({MEAS_REMOTE[9], MEAS_REMOTE}) + $signed({ofs[9], ofs});
  // Saturating keeps a large offset from wrapping a hot reading into a cold one.
  assign rem_new = (rem_sum > 11'sh1ff) ? 10'h1ff :
                   (rem_sum < -11'sh200) ? 10'h200 : rem_sum[9:0];

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      loc_val_q <= tsc_pkg::RST_ZERO;
      rem_val_q <= 10'h000;
    end else if (meas_take) begin
      loc_val_q <= MEAS_LOCAL;
      rem_val_q <= rem_new;
    end
  end

  assign loc10 = {MEAS_LOCAL, 2'h0};
  assign c_lhi = gt10(loc10, {loc_up_q, 2'h0});
  assign c_llo = ~gt10(loc10, {loc_lo_q, 2'h0});
  assign c_rhi = gt10(rem_new, {rem_up_hi_q, rem_up_lo_q});
  assign c_rlo = ~gt10(rem_new, {rem_lo_hi_q, rem_lo_lo_q});

  // R8: selector caps at four
  assign flt_loc.sample = meas_take;
  assign flt_loc.over = c_lhi | c_llo;
  assign flt_loc.count_sel = fc_q[tsc_pkg::FC_SEL_HI:tsc_pkg::FC_SEL_LO];
  assign flt_rem.sample = meas_take;
  assign flt_rem.over = c_rhi | c_rlo;
  assign flt_rem.count_sel = fc_q[tsc_pkg::FC_SEL_HI:tsc_pkg::FC_SEL_LO];

  tsc_fault_filter u_flt_loc (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .flt(flt_loc)
  );

  tsc_fault_filter u_flt_rem (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .flt(flt_rem)
  );

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      cond_q <= 5'h00;
    end else if (meas_take) begin
      cond_q <= {c_lhi, c_llo, c_rhi, c_rlo, MEAS_OPEN};
    end
  end

  assign flag_set = {flt_loc.trip & c_lhi, flt_loc.trip & c_llo,
                     flt_rem.trip & c_rhi, flt_rem.trip & c_rlo, meas_take & MEAS_OPEN};
  assign rd_flags = RD_REQ & (ptr_q == tsc_pkg::RA_FLAGS);

  // A new fault in the cycle of the clearing read is kept.
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      flag_q <= 5'h00;
    end else begin
      flag_q <= (flag_q & ~({5{rd_flags}} & ~cond_q)) | flag_set;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      lcrit_q <= 1'b0;
      rcrit_q <= 1'b0;
    end else if (meas_take) begin
      lcrit_q <= crit_next(lcrit_q, MEAS_LOCAL, loc_crit_q, hyst_q);
      rcrit_q <= crit_next(rcrit_q, rem_new[9:2], rem_crit_q, hyst_q);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= (|flag_q) & ~setup_q[tsc_pkg::SETUP_MASK_BIT];
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (ptr_q)
      tsc_pkg::RA_LOCAL_VAL: rd_mux = loc_val_q;
      tsc_pkg::RA_REM_VAL_HI: rd_mux = rem_val_q[9:2];
      tsc_pkg::RA_FLAGS: rd_mux = {conv_q == tsc_pkg::CV_WAIT, flag_q, rcrit_q, lcrit_q};
      tsc_pkg::RA_SETUP: rd_mux = setup_q;
      tsc_pkg::RA_RATE: rd_mux = rate_q;
      // R10: local upper read address
      tsc_pkg::RA_LOC_UP: rd_mux = loc_up_q;
      tsc_pkg::RA_LOC_LO: rd_mux = loc_lo_q;
      tsc_pkg::RA_REM_UP_HI: rd_mux = rem_up_hi_q;
      tsc_pkg::RA_REM_LO_HI: rd_mux = rem_lo_hi_q;
      // R11: remote low byte readback
      tsc_pkg::RA_REM_VAL_LO: rd_mux = {rem_val_q[1:0], 6'h00};
      tsc_pkg::A_OFS_HI: rd_mux = ofs_hi_q;
      tsc_pkg::A_OFS_LO: rd_mux = {ofs_lo_q, 6'h00};
      tsc_pkg::A_REM_UP_LO: rd_mux = {rem_up_lo_q, 6'h00};
      tsc_pkg::A_REM_LO_LO: rd_mux = {rem_lo_lo_q, 6'h00};
      tsc_pkg::A_REM_CRIT: rd_mux = rem_crit_q;
      tsc_pkg::A_LOC_CRIT: rd_mux = loc_crit_q;
      tsc_pkg::A_CRIT_HYST: rd_mux = hyst_q;
      tsc_pkg::A_FAULT_CNT: rd_mux = fc_q;
      tsc_pkg::RA_PART: rd_mux = PART_ID;
      tsc_pkg::RA_MAKER: rd_mux = MAKER_ID;
      tsc_pkg::RA_REV: rd_mux = REV_ID;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= RD_REQ;
      if (RD_REQ) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;
  assign BUS_TIMEOUT = bus_tmo_q;
  assign CONV_START = conv_start_q;
  assign ALERT_N_O = 1'b0;
  assign ALERT_N_OE = alert_q;
  assign CRITICAL_OVERTEMP_N_O = 1'b0;
  assign CRITICAL_OVERTEMP_N_OE = lcrit_q | rcrit_q;
endmodule

// file: shared/tsc_pkg.sv
// Shared register map, field positions, reset values, timing and types of the thermometer block.
package tsc_pkg;
  // Read-only or read-side addresses.
  localparam logic [7:0] RA_LOCAL_VAL = 8'h00;
  localparam logic [7:0] RA_REM_VAL_HI = 8'h01;
  localparam logic [7:0] RA_FLAGS = 8'h02;
  localparam logic [7:0] RA_SETUP = 8'h03;
  localparam logic [7:0] RA_RATE = 8'h04;
  localparam logic [7:0] RA_LOC_UP = 8'h05;
  localparam logic [7:0] RA_LOC_LO = 8'h06;
  localparam logic [7:0] RA_REM_UP_HI = 8'h07;
  localparam logic [7:0] RA_REM_LO_HI = 8'h08;
  localparam logic [7:0] RA_REM_VAL_LO = 8'h10;
  localparam logic [7:0] RA_PART = 8'h3d;
  localparam logic [7:0] RA_MAKER = 8'hfe;
  localparam logic [7:0] RA_REV = 8'hff;
  // Write-side addresses of split registers, and the write-only trigger.
  localparam logic [7:0] WA_SETUP = 8'h09;
  localparam logic [7:0] WA_RATE = 8'h0a;
  localparam logic [7:0] WA_LOC_UP = 8'h0b;
  localparam logic [7:0] WA_LOC_LO = 8'h0c;
  localparam logic [7:0] WA_REM_UP_HI = 8'h0d;
  localparam logic [7:0] WA_REM_LO_HI = 8'h0e;
  localparam logic [7:0] WA_TRIGGER = 8'h0f;
  // Addresses shared by read and write.
  localparam logic [7:0] A_OFS_HI = 8'h11;
  localparam logic [7:0] A_OFS_LO = 8'h12;
  localparam logic [7:0] A_REM_UP_LO = 8'h13;
  localparam logic [7:0] A_REM_LO_LO = 8'h14;
  localparam logic [7:0] A_REM_CRIT = 8'h19;
  localparam logic [7:0] A_LOC_CRIT = 8'h20;
  localparam logic [7:0] A_CRIT_HYST = 8'h21;
  localparam logic [7:0] A_FAULT_CNT = 8'h22;
  // Values after reset.
  localparam logic [7:0] RST_SETUP = 8'h08;
  localparam logic [7:0] RST_RATE = 8'h06;
  localparam logic [7:0] RST_UP = 8'h55;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CRIT = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0a;
  localparam logic [7:0] RST_FAULT_CNT = 8'h01;
  localparam logic [7:0] RST_PTR = 8'h00;
  // Field positions.
  localparam int SETUP_MASK_BIT = 7;
  localparam int SETUP_STBY_BIT = 6;
  localparam int FC_SEL_HI = 3;
  localparam int FC_SEL_LO = 1;
  localparam int FC_TMO_HI = 7;
  localparam int FC_TMO_LO = 6;
  localparam int FRAC_HI = 7;
  localparam int FRAC_LO = 6;
  localparam int FL_BUSY = 7;
  localparam int FL_LHI = 6;
  localparam int FL_OPEN = 2;
  // Timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_MS = 25;

  typedef enum logic {CV_IDLE, CV_WAIT} tsc_conv_t;
  typedef enum logic [1:0] {BP_IDLE, BP_PTR, BP_DATA} tsc_pos_t;

  // Conversion interval in milliseconds for each rate code.
  function automatic logic [13:0] rate_ms(input logic [7:0] code);
    case (code)
      8'h00: rate_ms = 14'h3e80;
      8'h01: rate_ms = 14'h1f40;
      8'h02: rate_ms = 14'h0fa0;
      8'h03: rate_ms = 14'h07d0;
      8'h04: rate_ms = 14'h03e8;
      8'h05: rate_ms = 14'h01f4;
      8'h06: rate_ms = 14'h00fa;
      8'h07: rate_ms = 14'h00c8;
      8'h08: rate_ms = 14'h0064;
      8'h09: rate_ms = 14'h0032;
      8'h0a: rate_ms = 14'h001b;
      default: rate_ms = 14'h00fa;
    endcase
  endfunction
endpackage

// file: shared/tsc_flt_if.sv
// Link between the register logic and one consecutive-fault filter.
`timescale 1ns/100ps
interface tsc_flt_if;
  logic sample;
  logic over;
  logic [2:0] count_sel;
  logic trip;
  modport owner (output sample, output over, output count_sel, input trip);
  modport filt (input sample, input over, input count_sel, output trip);
endinterface

// file: hdl/tsc_fault_filter.sv
// Consecutive out-of-limit counter for one measurement channel.
`timescale 1ns/100ps
module tsc_fault_filter (
  input wire logic clk,
  input wire logic rst_n,
  tsc_flt_if.filt flt
);
  logic [2:0] cnt_q;

  // Each set selector bit adds one required result; bit 0 of the field never arrives here.
  function automatic logic [2:0] need(input logic [2:0] sel);
    need = 3'h1 + {2'h0, sel[0]} + {2'h0, sel[1]} + {2'h0, sel[2]};
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else if (flt.sample) begin
      // R20: in-limit restarts count
      if (!flt.over) begin
        cnt_q <= 3'h0;
      end else if (cnt_q < need(flt.count_sel)) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // R7: trip at required count
  assign flt.trip = flt.sample & flt.over & ((cnt_q + 3'h1) >= need(flt.count_sel));
endmodule

// file: hdl/tsc_bus_timeout.sv
// Inactivity watchdog for a bus transaction, counted in millisecond ticks.
`timescale 1ns/100ps
module tsc_bus_timeout (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic ms_tick,
  input wire logic in_xfer,
  input wire logic activity,
  output logic timeout
);
  logic [4:0] cnt_q;
  logic fire;

  // The tick phase is free running, so the abandon comes one tick short of the full span at worst.
  assign fire = enable & in_xfer & ms_tick & (cnt_q == 5'(tsc_pkg::TIMEOUT_MS - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
    end else if (!enable || !in_xfer || activity || fire) begin
      cnt_q <= 5'h00;
    end else if (ms_tick) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // R15: abandon after idle span
  assign timeout = fire & ~activity;
endmodule

// file: bench/tsc_regs_asserts.sv
// Port-level assertions for the thermometer register block.
`timescale 1ns/100ps
module tsc_regs_asserts (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic XFER_START,
  input wire logic BUS_ACTIVE,
  input wire logic WR_VALID,
  input wire logic RD_REQ,
  input wire logic [7:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic BUS_TIMEOUT,
  input wire logic CONV_START,
  input wire logic MEAS_VALID,
  input wire logic ALERT_N_O,
  input wire logic ALERT_N_OE,
  input wire logic CRITICAL_OVERTEMP_N_O
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  rd_answer_a: assert property (RD_REQ |=> RD_VALID)
    else $error("read request not answered");
  rd_cause_a: assert property (RD_VALID |-> $past(RD_REQ))
    else $error("read answer without request");
  rd_hold_a: assert property (!RD_REQ |=> $stable(RD_DATA))
    else $error("read data moved without request");
  conv_gap_a: assert property (CONV_START |=> !CONV_START [*2])
    else $error("conversion start too close");
  od_low_a: assert property (!ALERT_N_O && !CRITICAL_OVERTEMP_N_O)
    else $error("open drain data not low");
  // Alert may only rise after a result or a register write.
  alert_cause_a: assert property ($rose(ALERT_N_OE) |-> $past(MEAS_VALID, 2) || $past(WR_VALID, 2))
    else $error("alert rose without cause");
  tmo_pulse_a: assert property (BUS_TIMEOUT |=> !BUS_TIMEOUT)
    else $error("timeout longer than one cycle");
  tmo_quiet_a: assert property (BUS_TIMEOUT |-> !$past(BUS_ACTIVE) && !$past(XFER_START))
    else $error("timeout right after activity");
endmodule
bind tsc_regs tsc_regs_asserts u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .XFER_START(XFER_START),
  .BUS_ACTIVE(BUS_ACTIVE), .WR_VALID(WR_VALID), .RD_REQ(RD_REQ), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .BUS_TIMEOUT(BUS_TIMEOUT), .CONV_START(CONV_START),
  .MEAS_VALID(MEAS_VALID), .ALERT_N_O(ALERT_N_O), .ALERT_N_OE(ALERT_N_OE),
  .CRITICAL_OVERTEMP_N_O(CRITICAL_OVERTEMP_N_O));

// file: bench/tsc_host_model.sv
// Bus host model driving byte-level register transactions at the falling edge.
`timescale 1ns/100ps
module tsc_host_model (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic xfer_start,
  output logic xfer_stop,
  output logic bus_active,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req
);
  initial {xfer_start, xfer_stop, bus_active, wr_valid, rd_req, wr_data} = 13'h0000;
  task automatic start();
    @(negedge clk);
    {xfer_start, bus_active} = 2'b11;
    @(negedge clk);
    {xfer_start, bus_active} = 2'b00;
  endtask
  task automatic stop();
    @(negedge clk);
    xfer_stop = 1'b1;
    @(negedge clk);
    xfer_stop = 1'b0;
  endtask
  // Released data shows the inverse so a stale byte is never mistaken for a fresh one.
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    {wr_valid, bus_active, wr_data} = {2'b11, b};
    @(negedge clk);
    {wr_valid, bus_active, wr_data} = {2'b00, ~b};
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input bit wd);
    start();
    put(p);
    if (wd) put(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] q, output bit ok);
    int n;
    wr(p, 8'h00, 1'b0);
    start();
    @(negedge clk);
    {rd_req, bus_active} = 2'b11;
    @(negedge clk);
    {rd_req, bus_active} = 2'b00;
    ok = 1'b0;
    q = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) {ok, q} = {1'b1, rd_data};
      else @(negedge clk);
    end
    stop();
  endtask
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the thermometer register block.
`timescale 1ns/100ps
module tb_top;
  localparam logic [15:0] RSTV [18] = '{16'h0000, 16'h0100, 16'h0308, 16'h0406, 16'h0555,
    16'h0600, 16'h0755, 16'h0800, 16'h0f00, 16'h1000, 16'h1100, 16'h1200, 16'h1300,
    16'h1955, 16'h2055, 16'h210a, 16'h2201, 16'h1500};
  localparam logic [31:0] WTAB [8] = '{32'h0b053c3c, 32'h0d075050, 32'h1313ffc0,
    32'h0e081010, 32'h14147f40, 32'h0101aa00, 32'h1515aa00, 32'h22220e0e};
  localparam logic [7:0] FCODE [4] = '{8'h00, 8'h03, 8'h06, 8'h0f};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic xfer_start, xfer_stop, bus_active, wr_valid, rd_req, rd_valid, bus_timeout;
  logic [7:0] wr_data, rd_data, q;
  logic conv_start, alert_n_oe, crit_oe;
  logic meas_valid = 1'b0;
  logic meas_open = 1'b0;
  logic [7:0] meas_local = 8'h20;
  logic [9:0] meas_remote = 10'h0c9;
  int fails = 0;
  int n_compared = 0;
  int convs = 0;
  int tmos = 0;
  bit ok;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (conv_start === 1'b1) convs <= convs + 1;
    if (bus_timeout === 1'b1) tmos <= tmos + 1;
  end
  tsc_host_model host (.clk(clk_sys), .rd_data(rd_data), .rd_valid(rd_valid),
    .xfer_start(xfer_start), .xfer_stop(xfer_stop), .bus_active(bus_active),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req));
  tsc_regs #(.MS_CYCLES(10)) uut (.CLK_SYS(clk_sys), .NRST(nrst), .XFER_START(xfer_start),
    .XFER_STOP(xfer_stop), .BUS_ACTIVE(bus_active), .WR_VALID(wr_valid), .WR_DATA(wr_data),
    .RD_REQ(rd_req), .RD_DATA(rd_data), .RD_VALID(rd_valid), .BUS_TIMEOUT(bus_timeout),
    .CONV_START(conv_start), .MEAS_VALID(meas_valid), .MEAS_LOCAL(meas_local),
    .MEAS_REMOTE(meas_remote), .MEAS_OPEN(meas_open), .ALERT_N_O(), .ALERT_N_OE(alert_n_oe),
    .CRITICAL_OVERTEMP_N_O(), .CRITICAL_OVERTEMP_N_OE(crit_oe));
  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q, ok);
    chk({7'h00, ok, q}, {8'h01, e});
  endtask
  task automatic conv(input logic [7:0] loc, input logic [9:0] rem);
    int n;
    int c0;
    c0 = convs;
    {meas_local, meas_remote} = {loc, rem};
    host.wr(8'h0f, 8'h77, 1'b1);
    for (n = 0; n < 20 && convs == c0; n++) @(negedge clk_sys);
    if (convs == c0) begin
      fails++;
      $display("[ERR] %0t no conversion start", $time);
      results();
    end
    repeat (3) @(negedge clk_sys);
    meas_valid = 1'b1;
    @(negedge clk_sys);
    meas_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  initial begin
    int i;
    int n;
    int t0;
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    for (i = 0; i < 18; i++) rchk(RSTV[i][15:8], RSTV[i][7:0]);
    for (i = 0; i < 8; i++) begin
      host.wr(WTAB[i][31:24], WTAB[i][15:8], 1'b1);
      rchk(WTAB[i][23:16], WTAB[i][7:0]);
    end
    host.wr(8'h09, 8'h40, 1'b1);
    host.wr(8'h0a, 8'h0a, 1'b1);
    t0 = convs;
    conv(8'h20, 10'h0c9);
    rchk(8'h01, 8'h32);
    rchk(8'h10, 8'h40);
    rchk(8'h0f, 8'h00);
    repeat (400) @(negedge clk_sys);
    chk(16'(convs - t0), 16'h0001);
    host.wr(8'h11, 8'hfe, 1'b1);
    host.wr(8'h12, 8'hc0, 1'b1);
    conv(8'h20, 10'h0c9);
    rchk(8'h01, 8'h31);
    rchk(8'h10, 8'h00);
    host.wr(8'h11, 8'h7f, 1'b1);
    conv(8'h20, 10'h000);
    rchk(8'h01, 8'h7f);
    rchk(8'h10, 8'hc0);
    host.wr(8'h11, 8'h00, 1'b1);
    host.wr(8'h12, 8'h00, 1'b1);
    for (i = 0; i < 4; i++) begin
      host.wr(8'h22, FCODE[i], 1'b1);
      conv(8'h20, 10'h0c9);
      rchk(8'h02, (i == 0) ? 8'h00 : 8'h40);
      repeat (i) conv(8'h60, 10'h0c9);
      conv(8'h20, 10'h0c9);
      repeat (i) conv(8'h60, 10'h0c9);
      chk({15'h0000, alert_n_oe}, 16'h0000);
      conv(8'h60, 10'h0c9);
      chk({15'h0000, alert_n_oe}, 16'h0001);
    end
    // A local reading above the default critical limit pulls the critical line.
    chk({15'h0000, crit_oe}, 16'h0001);
    host.start();
    host.put(8'h02);
    t0 = tmos;
    repeat (400) @(negedge clk_sys);
    chk(16'(tmos - t0), 16'h0000);
    host.stop();
    host.wr(8'h22, 8'hc1, 1'b1);
    host.start();
    host.put(8'h02);
    for (n = 0; n < 400 && tmos == t0; n++) @(negedge clk_sys);
    chk({15'h0000, n >= 230 && n <= 260}, 16'h0001);
    host.stop();
    nrst = 1'b0;
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    rchk(8'h22, 8'h01);
    results();
  end
endmodule
